// ### hdl/cctc_pkg.sv
package cctc_pkg;
  // Clock and timing base
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYC = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int BIT_PERIOD_NS = 1000;
  localparam int BIT_CYC = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_STEP_NS = 250;
  localparam int GAP_STEP_CYC = (GAP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Silence timeout durations, each in its own unit
  localparam int TMO1_MS = 100;
  localparam int TMO2_S = 2;
  localparam int TMO3_S = 10;
  localparam int TMO4_MIN = 1;
  localparam int TMO5_MIN = 10;
  localparam int TMO6_MIN = 30;
  localparam int TMO7_HR = 1;
  localparam int MS_PER_S = 1000;
  localparam int MS_PER_MIN = 60000;
  localparam int MS_PER_HR = 3600000;
  localparam logic [2:0] SEL_OFF = 3'h0;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_WDOG = 16'h0019;
  localparam logic [15:0] IDX_HOLD = 16'h001A;
  localparam logic [15:0] IDX_GAP = 16'h0029;
  localparam logic [15:0] IDX_BBP = 16'h002A;
  localparam logic [15:0] IDX_ROLE = 16'h0308;
  localparam logic [15:0] IDX_STAT = 16'h0400;
  localparam logic [15:0] IDX_MASK = 16'h0401;
  localparam logic [7:0] RST_REG8 = 8'h00;
  // Field positions and masks
  localparam int WDOG_SHORT_LSB = 4;
  localparam int WDOG_ACT_BIT = 3;
  localparam int WDOG_LONG_LSB = 0;
  localparam int ROLE_STACK_BIT = 1;
  localparam int ROLE_TOP_BIT = 0;
  localparam logic [7:0] ROLE_WMASK = 8'h03;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_LONG_BIT = 1;
  localparam logic [7:0] STAT_WMASK = 8'h03;
  localparam logic [4:0] BB_NONE = 5'h00;
  localparam logic [4:0] BB_LAST_MID = 5'h0F;
  localparam logic [4:0] BB_TOP_CODE = 5'h10;
  localparam logic [4:0] BB_TOP_CELL = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [21:0] cctc_sel_to_ms(input logic [2:0] sel);
    case (sel)
      3'h1: return 22'(TMO1_MS);
      3'h2: return 22'(TMO2_S * MS_PER_S);
      3'h3: return 22'(TMO3_S * MS_PER_S);
      3'h4: return 22'(TMO4_MIN * MS_PER_MIN);
      3'h5: return 22'(TMO5_MIN * MS_PER_MIN);
      3'h6: return 22'(TMO6_MIN * MS_PER_MIN);
      3'h7: return 22'(TMO7_HR * MS_PER_HR);
      default: return 22'h000000;
    endcase
  endfunction

  function automatic logic cctc_hit(input logic [15:0] a, input logic [15:0] idx);
    return a == {idx[13:0], 2'h0};
  endfunction
endpackage

// ### hdl/cctc_ifs.sv
interface cctc_tmr_if;
  logic tick;
  logic restart;
  logic [2:0] sel;
  logic expire;
  modport ctrl(output tick, output restart, output sel, input expire);
  modport tmr(input tick, input restart, input sel, output expire);
endinterface

interface cctc_pace_if;
  logic start;
  logic [15:0] limit;
  logic done;
  modport ctrl(output start, output limit, input done);
  modport pace(input start, input limit, output done);
endinterface

// ### hdl/cctc_silence_timer.sv
module cctc_silence_timer import cctc_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control side
  cctc_tmr_if.tmr tif
);
  typedef struct packed {
    logic run;
    logic [21:0] ms_cnt;
    logic expire;
  } cctc_tmr_state_type;

  cctc_tmr_state_type q, d;

  always_comb begin
    d = q;
    d.expire = 1'b0;
    if (tif.sel == SEL_OFF) begin
      d.run = 1'b0;
      d.ms_cnt = '0;
    end else if (tif.restart) begin
      d.run = 1'b1;
      d.ms_cnt = '0;
    end else if (q.run && tif.tick) begin
      if (q.ms_cnt + 22'h000001 >= cctc_sel_to_ms(tif.sel)) begin
        d.expire = 1'b1;
        d.run = 1'b0;
      end else begin
        d.ms_cnt = q.ms_cnt + 22'h000001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.expire = q.expire;

  dur_reach_a: assert property (@(posedge clk_in) disable iff (rst_in)
    tif.expire |-> ($past(q.ms_cnt) + 22'h000001 == cctc_sel_to_ms($past(tif.sel))))
    else $error("timeout fired at the wrong count");
  sel_off_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (tif.sel == SEL_OFF) |=> !tif.expire)
    else $error("disabled timer expired");
  restart_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
    tif.restart |=> !tif.expire ##1 !tif.expire)
    else $error("timer expired right after restart");
endmodule

// ### hdl/cctc_pacer.sv
module cctc_pacer import cctc_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control side
  cctc_pace_if.pace pif
);
  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
    logic done;
  } cctc_pace_state_type;

  cctc_pace_state_type q, d;

  // A new start restarts a countdown already running
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (pif.start) begin
      d.busy = 1'b1;
      d.cnt = pif.limit;
    end else if (q.busy) begin
      if (q.cnt == 16'h0000) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pif.done = q.done;

  zero_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (pif.start && pif.limit == 16'h0000) ##1 !pif.start |-> ##1 pif.done)
    else $error("zero wait did not finish at once");
  count_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.busy && q.cnt != 16'h0000 && !pif.start) |=> !pif.done)
    else $error("wait ended early");
endmodule

// ### hdl/cctc_top.sv
// The AXI4-Lite slave port was chosen for this implementation.
module cctc_top import cctc_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_TICK_CYC
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // AXI4-Lite write channels
  input wire logic [15:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  // AXI4-Lite read channels
  input wire logic [15:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  // Communication events
  input wire logic COMM_VALID_IN,
  input wire logic CMD_STOP_IN,
  input wire logic BYTE_DONE_IN,
  // Frame pacing
  output logic RESP_START_OUT,
  output logic BYTE_GO_OUT,
  // Power requests and fault
  output logic SLEEP_REQ_OUT,
  output logic SHUTDOWN_REQ_OUT,
  output logic COMM_TIMEOUT_FAULT_OUT,
  // Busbar placement for the measurement path
  output logic BB_IN_USE_OUT,
  output logic BB_TOP_OUT,
  output logic [4:0] BB_POS_CELL_OUT,
  output logic [4:0] BB_NEG_VC_OUT,
  // Chain role
  output logic STACK_DEV_OUT,
  output logic CHAIN_TOP_OUT,
  // Interrupt
  output logic IRQ_OUT
);
  typedef struct packed {
    logic aw_have;
    logic [15:0] aw_addr;
    logic w_have;
    logic [7:0] w_byte;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] wdog;
    logic [7:0] hold;
    logic [7:0] gap;
    logic [7:0] busbar_pos_input;
    logic [7:0] role;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [15:0] tick_cnt;
    logic tick;
    logic restart;
    logic sleep_req;
    logic shut_req;
    logic irq;
    logic bb_use;
    logic bb_top;
    logic [4:0] bb_pos;
    logic [4:0] bb_neg;
  } cctc_top_state_type;

  cctc_top_state_type q, d;

  cctc_tmr_if t_short();
  cctc_tmr_if t_long();
  cctc_pace_if p_hold();
  cctc_pace_if p_gap();

  // Timers see the registered tick and restart pulse
  assign t_short.tick = q.tick;
  assign t_short.restart = q.restart;
  assign t_short.sel = q.wdog[WDOG_SHORT_LSB +: 3];
  assign t_long.tick = q.tick;
  assign t_long.restart = q.restart;
  assign t_long.sel = q.wdog[WDOG_LONG_LSB +: 3];

  assign p_hold.start = CMD_STOP_IN;
  assign p_hold.limit = 16'(q.hold) * 16'(BIT_CYC);
  assign p_gap.start = BYTE_DONE_IN;
  assign p_gap.limit = 16'(q.gap[5:0]) * 16'(GAP_STEP_CYC);

  cctc_silence_timer u_short (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .tif(t_short)
  );

  cctc_silence_timer u_long (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .tif(t_long)
  );

  cctc_pacer u_hold (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .pif(p_hold)
  );

  cctc_pacer u_gap (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .pif(p_gap)
  );

  always_comb begin
    logic [7:0] wb;
    logic [7:0] clr;
    logic [7:0] set;
    logic [7:0] rd;
    logic act;
    logic [4:0] busbar_loc_code;
    wb = q.w_byte;
    clr = 8'h00;
    set = 8'h00;
    rd = 8'h00;
    act = q.wdog[WDOG_ACT_BIT];
    busbar_loc_code = q.busbar_pos_input[4:0];
    d = q;
    d.tick = 1'b0;
    d.restart = COMM_VALID_IN;
    d.sleep_req = 1'b0;
    d.shut_req = 1'b0;
    // Millisecond time base for the silence timers
    if (q.tick_cnt == 16'(MS_TICK_CYCLES - 1)) begin
      d.tick_cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 16'h0001;
    end
    // Write address and data are taken independently
    if (AXI_AWVALID_IN && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && q.wready) begin
      d.w_have = 1'b1;
      d.w_byte = AXI_WDATA_IN[7:0];
      d.w_strb0 = AXI_WSTRB_IN[0];
    end
    if (q.bvalid && AXI_BREADY_IN) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (cctc_hit(q.aw_addr, IDX_WDOG)) begin
        if (q.w_strb0) begin
          d.wdog = wb;
          d.restart = 1'b1;
        end
      end else if (cctc_hit(q.aw_addr, IDX_HOLD)) begin
        if (q.w_strb0) begin
          d.hold = wb;
        end
      end else if (cctc_hit(q.aw_addr, IDX_GAP)) begin
        if (q.w_strb0) begin
          d.gap = wb;
        end
      end else if (cctc_hit(q.aw_addr, IDX_BBP)) begin
        if (q.w_strb0) begin
          d.busbar_pos_input = wb;
        end
      end else if (cctc_hit(q.aw_addr, IDX_ROLE)) begin
        if (q.w_strb0) begin
          d.role = wb & ROLE_WMASK;
        end
      end else if (cctc_hit(q.aw_addr, IDX_STAT)) begin
        if (q.w_strb0) begin
          clr = wb & STAT_WMASK;
        end
      end else if (cctc_hit(q.aw_addr, IDX_MASK)) begin
        if (q.w_strb0) begin
          d.mask = wb & STAT_WMASK;
        end
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    // Timer expiry; a new event wins over a same-cycle clear
    set[STAT_FAULT_BIT] = t_short.expire || (t_long.expire && !act);
    set[STAT_LONG_BIT] = t_long.expire;
    d.stat = (q.stat & ~clr) | set;
    d.sleep_req = t_long.expire && !act;
    d.shut_req = t_long.expire && act;
    d.irq = |(d.stat & d.mask);
    // Read channel
    if (q.rvalid && AXI_RREADY_IN) begin
      d.rvalid = 1'b0;
    end
    if (AXI_ARVALID_IN && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      if (cctc_hit(AXI_ARADDR_IN, IDX_WDOG)) begin
        rd = q.wdog;
      end else if (cctc_hit(AXI_ARADDR_IN, IDX_HOLD)) begin
        rd = q.hold;
      end else if (cctc_hit(AXI_ARADDR_IN, IDX_GAP)) begin
        rd = q.gap;
      end else if (cctc_hit(AXI_ARADDR_IN, IDX_BBP)) begin
        rd = q.busbar_pos_input;
      end else if (cctc_hit(AXI_ARADDR_IN, IDX_ROLE)) begin
        rd = q.role;
      end else if (cctc_hit(AXI_ARADDR_IN, IDX_STAT)) begin
        rd = q.stat;
      end else if (cctc_hit(AXI_ARADDR_IN, IDX_MASK)) begin
        rd = q.mask;
      end else begin
        d.rresp = RESP_SLVERR;
      end
      d.rdata = {24'h000000, rd};
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
    // Busbar placement, used as the common-mode reference of busbar conversions
    d.bb_use = 1'b0;
    d.bb_top = 1'b0;
    d.bb_pos = BB_NONE;
    d.bb_neg = BB_NONE;
    if (busbar_loc_code != BB_NONE && busbar_loc_code <= BB_LAST_MID) begin
      d.bb_use = 1'b1;
      d.bb_pos = busbar_loc_code + 5'h01;
      d.bb_neg = busbar_loc_code;
    end else if (busbar_loc_code == BB_TOP_CODE) begin
      d.bb_use = 1'b1;
      d.bb_top = 1'b1;
      d.bb_pos = BB_TOP_CELL;
      d.bb_neg = BB_TOP_CELL;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q <= '0;
      q.wdog <= RST_REG8;
      q.hold <= RST_REG8;
      q.gap <= RST_REG8;
      q.busbar_pos_input <= RST_REG8;
      q.role <= RST_REG8;
      q.stat <= RST_REG8;
      q.mask <= RST_REG8;
    end else begin
      q <= d;
    end
  end

  assign AXI_AWREADY_OUT = q.awready;
  assign AXI_WREADY_OUT = q.wready;
  assign AXI_BRESP_OUT = q.bresp;
  assign AXI_BVALID_OUT = q.bvalid;
  assign AXI_ARREADY_OUT = q.arready;
  assign AXI_RDATA_OUT = q.rdata;
  assign AXI_RRESP_OUT = q.rresp;
  assign AXI_RVALID_OUT = q.rvalid;
  assign RESP_START_OUT = p_hold.done;
  assign BYTE_GO_OUT = p_gap.done;
  assign SLEEP_REQ_OUT = q.sleep_req;
  assign SHUTDOWN_REQ_OUT = q.shut_req;
  assign COMM_TIMEOUT_FAULT_OUT = q.stat[STAT_FAULT_BIT];
  assign BB_IN_USE_OUT = q.bb_use;
  assign BB_TOP_OUT = q.bb_top;
  assign BB_POS_CELL_OUT = q.bb_pos;
  assign BB_NEG_VC_OUT = q.bb_neg;
  assign STACK_DEV_OUT = q.role[ROLE_STACK_BIT];
  assign CHAIN_TOP_OUT = q.role[ROLE_TOP_BIT];
  assign IRQ_OUT = q.irq;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence long_sleep_s;
    t_long.expire && !q.wdog[WDOG_ACT_BIT];
  endsequence
  sequence long_shut_s;
    t_long.expire && q.wdog[WDOG_ACT_BIT] && !t_short.expire && !q.stat[STAT_FAULT_BIT];
  endsequence

  // A long expiry in the same cycle may legally request a power change
  short_fault_a: assert property ((t_short.expire && !t_long.expire) |=> COMM_TIMEOUT_FAULT_OUT
    && !SLEEP_REQ_OUT
    && !SHUTDOWN_REQ_OUT)
    else $error("short expiry did not only raise the fault");
  long_sleep_a: assert property (long_sleep_s |=> SLEEP_REQ_OUT && COMM_TIMEOUT_FAULT_OUT)
    else $error("sleep action missing");
  long_shut_a: assert property (long_shut_s |=> SHUTDOWN_REQ_OUT && !COMM_TIMEOUT_FAULT_OUT)
    else $error("shutdown action wrong");
  // A second stop bit right behind the first restarts the wait
  holdoff_zero_a: assert property ((CMD_STOP_IN && q.hold == 8'h00) ##1 !CMD_STOP_IN |-> ##1 RESP_START_OUT)
    else $error("zero hold-off response late");
  gap_zero_a: assert property ((BYTE_DONE_IN && q.gap[5:0] == 6'h00) ##1 !BYTE_DONE_IN |-> ##1 BYTE_GO_OUT)
    else $error("zero byte gap late");
  bb_none_a: assert property ((q.busbar_pos_input[4:0] == BB_NONE) |=> !BB_IN_USE_OUT)
    else $error("busbar shown in use for code zero");
  bb_mid_a: assert property ((q.busbar_pos_input[4:0] != BB_NONE && q.busbar_pos_input[4:0] <= BB_LAST_MID)
    |=> BB_IN_USE_OUT && BB_NEG_VC_OUT == $past(q.busbar_pos_input[4:0]) && BB_POS_CELL_OUT == BB_NEG_VC_OUT + 5'h01)
    else $error("busbar mid placement wrong");
  bb_top_a: assert property ((q.busbar_pos_input[4:0] == BB_TOP_CODE) |=> BB_TOP_OUT && BB_POS_CELL_OUT == BB_TOP_CELL)
    else $error("busbar top placement wrong");
endmodule

// ### sim/cctc_link_model.sv
module cctc_link_model (
  // Clock
  input wire logic clk_in,
  // Events towards the block
  output logic comm_valid_out,
  output logic cmd_stop_out,
  output logic byte_done_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {comm_valid_out, cmd_stop_out, byte_done_out} = 3'h0;
  end

  // One single-cycle event: 0 valid traffic, 1 command stop bit, 2 response byte done
  task automatic pulse(input int kind);
    @(posedge clk_in);
    {comm_valid_out, cmd_stop_out, byte_done_out} <= {kind == 0, kind == 1, kind == 2};
    @(posedge clk_in);
    {comm_valid_out, cmd_stop_out, byte_done_out} <= 3'h0;
  endtask
endmodule

// ### sim/cctc_top_tb.sv
module cctc_top_tb import cctc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // Short ms tick keeps the silence timers within the run
  localparam int TICK = 4;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, comm, stop, bdone, rstart, bgo;
  logic sleep, shut, fault, bbuse, bbtop, stack, top, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] bbpos, bbneg;
  int fail_count = 0;
  int n_tests = 0;
  int n_sleep = 0;
  int n_shut = 0;
  logic [15:0] regs [7] = '{IDX_WDOG, IDX_HOLD, IDX_GAP, IDX_BBP, IDX_ROLE, IDX_STAT, IDX_MASK};
  logic [7:0] hc [3] = '{8'h00, 8'h01, 8'hFF};
  logic [7:0] gc [3] = '{8'h00, 8'h01, 8'h3F};
  logic [7:0] rc [4] = '{8'h01, 8'h02, 8'h00, 8'hFF};

  cctc_top #(.MS_TICK_CYCLES(TICK)) i_dut (.REF_CLK_IN(clk), .RST_IN(rst),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awrdy), .AXI_WDATA_IN(wdata),
    .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrdy), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arv),
    .AXI_ARREADY_OUT(arrdy), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
    .AXI_RREADY_IN(rready), .COMM_VALID_IN(comm), .CMD_STOP_IN(stop), .BYTE_DONE_IN(bdone),
    .RESP_START_OUT(rstart), .BYTE_GO_OUT(bgo), .SLEEP_REQ_OUT(sleep), .SHUTDOWN_REQ_OUT(shut),
    .COMM_TIMEOUT_FAULT_OUT(fault), .BB_IN_USE_OUT(bbuse), .BB_TOP_OUT(bbtop), .BB_POS_CELL_OUT(bbpos),
    .BB_NEG_VC_OUT(bbneg), .STACK_DEV_OUT(stack), .CHAIN_TOP_OUT(top), .IRQ_OUT(irq));

  cctc_link_model i_link (.clk_in(clk), .comm_valid_out(comm), .cmd_stop_out(stop), .byte_done_out(bdone));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Power request pulses are counted as they pass
  always @(posedge clk) begin
    if (sleep === 1'h1) n_sleep++;
    if (shut === 1'h1) n_shut++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic [15:0] ba(input logic [15:0] idx);
    return {idx[13:0], 2'h0};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    {awv, wv, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (awrdy === 1'h1) awv <= 1'h0;
      if (wrdy === 1'h1) wv <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    check(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    {arv, rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (arrdy === 1'h1) arv <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    check(rdata, {24'h000000, d});
    check(32'(rresp), 32'(er));
  endtask

  // Start event to pacer output, counted in edges after the event is taken
  task automatic pace(input logic [15:0] idx, input int kind, input logic [7:0] code, input int step);
    int n;
    wr(ba(idx), code, RESP_OKAY);
    i_link.pulse(kind);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (((kind == 1) ? rstart : bgo) !== 1'h1 && n < 20000);
    check(32'(n), 32'(2 + code * step));
  endtask

  task automatic tmr(input logic [7:0] cfg, input int ms, input int kicks, input logic [7:0] st);
    int s0;
    int d0;
    wr(ba(IDX_STAT), 8'h03, RESP_OKAY);
    s0 = n_sleep;
    d0 = n_shut;
    wr(ba(IDX_WDOG), cfg, RESP_OKAY);
    repeat (kicks) begin
      repeat (ms * TICK / 2) @(posedge clk);
      i_link.pulse(0);
    end
    repeat (ms * TICK - 10) @(posedge clk);
    check(32'(fault), 32'h0);
    check(32'(n_sleep + n_shut - s0 - d0), 32'h0);
    repeat (30) @(posedge clk);
    rd(ba(IDX_STAT), st, RESP_OKAY);
    check(32'(fault), 32'(st[0]));
    check(32'(n_sleep - s0), 32'(cfg[2:0] != 3'h0 && !cfg[3]));
    check(32'(n_shut - d0), 32'(cfg[2:0] != 3'h0 && cfg[3]));
    wr(ba(IDX_WDOG), 8'h00, RESP_OKAY);
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    test_done();
  end

  initial begin
    logic iu;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    check(32'({sleep, shut, fault, bbuse, bbtop, stack, top, irq, rstart, bgo}), 32'h0);
    foreach (regs[i]) rd(ba(regs[i]), 8'h00, RESP_OKAY);
    for (int i = 1; i < 4; i++) begin
      wr(ba(regs[i]), 8'hA5, RESP_OKAY);
      rd(ba(regs[i]), 8'hA5, RESP_OKAY);
    end
    wr(ba(IDX_WDOG), 8'h80, RESP_OKAY);
    rd(ba(IDX_WDOG), 8'h80, RESP_OKAY);
    // Lane 0 disabled: the write is answered but changes nothing
    wstrb <= 4'hE;
    wr(ba(IDX_HOLD), 8'h3C, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ba(IDX_HOLD), 8'hA5, RESP_OKAY);
    wr(16'h0004, 8'hFF, RESP_SLVERR);
    rd(16'h0004, 8'h00, RESP_SLVERR);
    fin("registers");
    foreach (rc[i]) begin
      wr(ba(IDX_ROLE), rc[i], RESP_OKAY);
      repeat (2) @(posedge clk);
      check(32'({stack, top}), 32'(rc[i][1:0]));
    end
    rd(ba(IDX_ROLE), 8'h03, RESP_OKAY);
    fin("role");
    for (int c = 0; c < 19; c++) begin
      wr(ba(IDX_BBP), 8'(c), RESP_OKAY);
      repeat (2) @(posedge clk);
      iu = (c >= 1 && c <= 16);
      check(32'({bbuse, bbtop, bbneg}), 32'({iu, c == 16, iu ? 5'(c) : 5'h00}));
      if (iu) check(32'(bbpos), 32'((c == 16) ? 16 : c + 1));
    end
    fin("busbar");
    foreach (hc[i]) pace(IDX_HOLD, 1, hc[i], BIT_CYC);
    foreach (gc[i]) pace(IDX_GAP, 2, gc[i], GAP_STEP_CYC);
    fin("pacing");
    tmr(8'h10, 100, 0, 8'h01);
    check(32'(irq), 32'h0);
    wr(ba(IDX_MASK), 8'h01, RESP_OKAY);
    rd(ba(IDX_MASK), 8'h01, RESP_OKAY);
    check(32'(irq), 32'h1);
    wr(ba(IDX_STAT), 8'h01, RESP_OKAY);
    rd(ba(IDX_STAT), 8'h00, RESP_OKAY);
    check(32'(irq), 32'h0);
    fin("interrupt");
    tmr(8'h11, 100, 3, 8'h03);
    tmr(8'h09, 100, 0, 8'h02);
    tmr(8'h20, 2000, 0, 8'h01);
    tmr(8'h02, 2000, 0, 8'h03);
    tmr(8'h08, 100, 0, 8'h00);
    fin("timers");
    test_done();
  end
endmodule
